//--- rtl/dmae_engine.v
`timescale 1ns/100ps
`include "dmae_defs.vh"

module dmae_engine
(
	input  wire        pclk,    // bus clock
	input  wire        presetn, // async reset, low
	input  wire        psel,    // slave select
	input  wire        penable, // access phase
	input  wire        pwrite,  // write transfer
	input  wire [7:0]  paddr,   // byte address
	input  wire [31:0] pwdata,  // write data
	output wire        pready,  // transfer done
	output reg  [31:0] prdata,  // read data
	output reg         pslverr  // unmapped address
);

	localparam ST_IDLE = 2'b01;
	localparam ST_ACC  = 2'b10;

	reg  [1:0]  st;
	reg  [7:0]  core_config_reg;
	reg  [15:0] opnd_x;
	reg  [15:0] opnd_y;
	reg  [39:0] accumulator_a;
	reg  [39:0] accumulator_b;
	reg         acc_a_guard_overflow;
	reg         acc_b_guard_overflow;
	reg         acc_a_clamp_sticky;
	reg         acc_b_clamp_sticky;
	reg  [31:0] product;

	wire        setup;
	wire        wr;
	wire        frac;
	wire        mult_sign_sel;
	wire        round_mode_sel;
	wire        clamp_width_select;
	wire        store_clamp_enable;
	wire        acc_a_clamp_enable;
	wire        acc_b_clamp_enable;

	assign pready             = st[1];
	assign setup              = psel & ~penable;
	assign wr                 = psel & penable & pready & pwrite;
	assign frac               = core_config_reg[`DMAE_CFG_FRAC];
	assign mult_sign_sel      = core_config_reg[`DMAE_CFG_USGN];
	assign round_mode_sel     = core_config_reg[`DMAE_CFG_RND];
	assign clamp_width_select = core_config_reg[`DMAE_CFG_W32];
	assign store_clamp_enable = core_config_reg[`DMAE_CFG_STC];
	assign acc_b_clamp_enable = core_config_reg[`DMAE_CFG_CLB];
	assign acc_a_clamp_enable = core_config_reg[`DMAE_CFG_CLA];

	// 17x17 multiply plus scaler, 40-bit result
	function [39:0] mult;
		input [15:0] a;
		input [15:0] b;
		input        au;
		input        bu;
		input        fr;
		reg   [16:0] ea;
		reg   [16:0] eb;
		reg signed [33:0] p;
		reg   [33:0] s;
		begin
			ea = {(au ? 1'b0 : a[15]), a};
			eb = {(bu ? 1'b0 : b[15]), b};
			p = $signed(ea) * $signed(eb);
			s = fr ? {p[32:0], 1'b0} : p;
			mult = {{7{s[32]}}, s[32:0]};
		end
	endfunction

	// round high word and optionally clamp to 1.15
	function [15:0] rnd_store;
		input [39:0] acc;
		input        conv;
		input        clamp;
		reg          inc;
		reg   [23:0] h;
		begin
			inc = acc[15] & (~conv | (acc[15:0] != `DMAE_HALF)
				| acc[16]);
			h = acc[39:16] + {23'h000000, inc};
			if (clamp && (h[23:15] != {9{h[23]}}))
				rnd_store = h[23] ? `DMAE_Q15N : `DMAE_Q15P;
			else
				rnd_store = h[15:0];
		end
	endfunction

	// address is a mapped register
	function hit;
		input [7:0] a;
		begin
			case (a)
				`DMAE_A_CFG, `DMAE_A_OPND, `DMAE_A_CMD,
				`DMAE_A_STAT, `DMAE_A_ACCALO,
				`DMAE_A_ACCAHI, `DMAE_A_ACCBLO,
				`DMAE_A_ACCBHI, `DMAE_A_STORE,
				`DMAE_A_PROD:
					hit = 1'b1;
				default:
					hit = 1'b0;
			endcase
		end
	endfunction

	// command decode
	wire [3:0]  op;
	wire        tsel;
	wire [5:0]  sh;
	wire [5:0]  nsh;
	wire [39:0] src;
	wire [39:0] oth;
	wire [15:0] diff;
	wire [39:0] prod;
	wire [39:0] sq;
	wire [39:0] dat;
	reg  [39:0] shd;

	assign op   = pwdata[`DMAE_CMD_OP];
	assign tsel = pwdata[`DMAE_CMD_ACC];
	assign sh   = pwdata[`DMAE_CMD_SH];
	assign nsh  = 6'h00 - sh;
	assign src  = tsel ? accumulator_b : accumulator_a;
	assign oth  = tsel ? accumulator_a : accumulator_b;
	assign diff = opnd_x - opnd_y;
	assign prod = mult(opnd_x, opnd_y, mult_sign_sel,
		mult_sign_sel, frac);
	assign sq   = mult(diff, diff, mult_sign_sel,
		mult_sign_sel, frac);
	assign dat  = {{8{opnd_x[15]}}, opnd_x, 16'h0000};

	// barrel shift: positive right, negative left
	always @*
	begin
		if (sh[5])
			shd = dat << nsh;
		else
			shd = $signed(dat) >>> sh;
	end

	reg  [39:0] base;
	reg  [39:0] addend;
	reg         sub;
	reg         pass;

	always @*
	begin
		base   = 40'h0000000000;
		addend = 40'h0000000000;
		sub    = 1'b0;
		pass   = 1'b1;
		case (op)
			`DMAE_OP_CLR:  ;
			`DMAE_OP_ED:   addend = sq;
			`DMAE_OP_ACCUM_SQUARE_DIFF:
			begin
				base   = src;
				addend = sq;
			end
			`DMAE_OP_MACC:
			begin
				base   = src;
				addend = prod;
			end
			`DMAE_OP_MLD:  addend = prod;
			`DMAE_OP_MNLD:
			begin
				addend = prod;
				sub    = 1'b1;
			end
			`DMAE_OP_MSUB:
			begin
				base   = src;
				addend = prod;
				sub    = 1'b1;
			end
			`DMAE_OP_ADDA:
			begin
				base   = src;
				addend = oth;
			end
			`DMAE_OP_SUBA:
			begin
				base   = src;
				addend = oth;
				sub    = 1'b1;
			end
			`DMAE_OP_NEGA:
			begin
				addend = src;
				sub    = 1'b1;
			end
			`DMAE_OP_LOAD: addend = shd;
			`DMAE_OP_ADDD:
			begin
				base   = src;
				addend = shd;
			end
			default:       pass = 1'b0;
		endcase
	end

	// 41-bit adder keeps the true sign
	wire [40:0] a41;
	wire [40:0] b41;
	wire [40:0] sum;
	wire [39:0] r;
	wire        o39;
	wire        o31;
	wire        g;
	wire        en;

	assign a41 = {base[39], base};
	assign b41 = {addend[39], addend};
	assign sum = sub ? a41 - b41 : a41 + b41;
	assign r   = sum[39:0];
	assign o39 = sum[40] ^ sum[39];
	assign g   = ~((&r[39:32]) | ~(|r[39:32]));
	assign o31 = o39 | ~((&r[39:31]) | ~(|r[39:31]));
	assign en  = tsel ? acc_b_clamp_enable
		: acc_a_clamp_enable;

	reg  [39:0] res;
	reg         sset;
	reg         gflag;

	always @*
	begin
		res   = r;
		sset  = o39;
		gflag = g;
		if (en && clamp_width_select)
		begin
			sset  = o31;
			gflag = 1'b0;
			if (o31)
				res = sum[40] ? `DMAE_SAT32N
					: `DMAE_SAT32P;
		end
		else if (en && o39)
			res = sum[40] ? `DMAE_SAT40N
				: `DMAE_SAT40P;
	end

	// integer multiply for the general instruction set
	wire        xu;
	wire        yu;
	wire [15:0] bx;
	wire [15:0] by;
	wire [39:0] mw;
	wire [39:0] mb;

	assign xu = pwdata[`DMAE_CMD_XU];
	assign yu = pwdata[`DMAE_CMD_YU];
	assign bx = {(xu ? 8'h00 : {8{opnd_x[7]}}), opnd_x[7:0]};
	assign by = {(yu ? 8'h00 : {8{opnd_y[7]}}), opnd_y[7:0]};
	assign mw = mult(opnd_x, opnd_y, xu, yu, 1'b0);
	assign mb = mult(bx, by, xu, yu, 1'b0);

	wire        cmd_wr;
	wire        stat_wr;
	wire [31:0] store_word;

	assign cmd_wr     = wr && (paddr == `DMAE_A_CMD);
	assign stat_wr    = wr && (paddr == `DMAE_A_STAT);
	assign store_word = {
		rnd_store(accumulator_b, round_mode_sel,
			store_clamp_enable),
		rnd_store(accumulator_a, round_mode_sel,
			store_clamp_enable)};

	// bus state and read data
	reg  [31:0] rdata;

	always @*
	begin
		case (paddr)
			`DMAE_A_CFG:    rdata = {24'h000000, core_config_reg};
			`DMAE_A_OPND:   rdata = {opnd_y, opnd_x};
			`DMAE_A_STAT:   rdata = {26'h0000000,
				acc_a_clamp_sticky | acc_b_clamp_sticky,
				acc_a_guard_overflow | acc_b_guard_overflow,
				acc_b_clamp_sticky, acc_a_clamp_sticky,
				acc_b_guard_overflow, acc_a_guard_overflow};
			`DMAE_A_ACCALO: rdata = accumulator_a[31:0];
			`DMAE_A_ACCAHI: rdata = {24'h000000,
				accumulator_a[39:32]};
			`DMAE_A_ACCBLO: rdata = accumulator_b[31:0];
			`DMAE_A_ACCBHI: rdata = {24'h000000,
				accumulator_b[39:32]};
			`DMAE_A_STORE:  rdata = store_word;
			`DMAE_A_PROD:   rdata = product;
			default:        rdata = 32'h00000000;
		endcase
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st      <= ST_IDLE;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else
		begin
			case (st)
				ST_IDLE: if (setup) st <= ST_ACC;
				ST_ACC:  st <= setup ? ST_ACC : ST_IDLE;
				default: st <= ST_IDLE;
			endcase
			if (setup)
			begin
				prdata  <= rdata;
				pslverr <= ~hit(paddr);
			end
		end
	end

	// register file and accumulators
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			core_config_reg      <= `DMAE_CFG_RST;
			opnd_x               <= 16'h0000;
			opnd_y               <= 16'h0000;
			accumulator_a        <= 40'h0000000000;
			accumulator_b        <= 40'h0000000000;
			acc_a_guard_overflow <= 1'b0;
			acc_b_guard_overflow <= 1'b0;
			acc_a_clamp_sticky   <= 1'b0;
			acc_b_clamp_sticky   <= 1'b0;
			product              <= 32'h00000000;
		end
		else
		begin
			if (wr)
			begin
				case (paddr)
					`DMAE_A_CFG:
						core_config_reg <= pwdata[7:0];
					`DMAE_A_OPND:
					begin
						opnd_x <= pwdata[15:0];
						opnd_y <= pwdata[31:16];
					end
					`DMAE_A_ACCALO:
						accumulator_a[31:0] <= pwdata;
					`DMAE_A_ACCAHI:
						accumulator_a[39:32] <= pwdata[7:0];
					`DMAE_A_ACCBLO:
						accumulator_b[31:0] <= pwdata;
					`DMAE_A_ACCBHI:
						accumulator_b[39:32] <= pwdata[7:0];
					default: ;
				endcase
			end
			if (cmd_wr && pass && !tsel)
			begin
				accumulator_a        <= res;
				acc_a_guard_overflow <= gflag;
			end
			if (cmd_wr && pass && tsel)
			begin
				accumulator_b        <= res;
				acc_b_guard_overflow <= gflag;
			end
			// set wins over a same-cycle clear
			acc_a_clamp_sticky <= (acc_a_clamp_sticky
				& ~(stat_wr & pwdata[`DMAE_ST_SA]))
				| (cmd_wr & pass & ~tsel & sset);
			acc_b_clamp_sticky <= (acc_b_clamp_sticky
				& ~(stat_wr & pwdata[`DMAE_ST_SB]))
				| (cmd_wr & pass & tsel & sset);
			if (cmd_wr && op == `DMAE_OP_MCU)
				product <= pwdata[`DMAE_CMD_BYTE]
					? {16'h0000, mb[15:0]}
					: mw[31:0];
		end
	end

endmodule // dmae_engine

//--- rtl/dmae_defs.vh
`ifndef DMAE_DEFS_VH
`define DMAE_DEFS_VH

// register byte addresses
`define DMAE_A_CFG    8'h00
`define DMAE_A_OPND   8'h04
`define DMAE_A_CMD    8'h08
`define DMAE_A_STAT   8'h0C
`define DMAE_A_ACCALO 8'h10
`define DMAE_A_ACCAHI 8'h14
`define DMAE_A_ACCBLO 8'h18
`define DMAE_A_ACCBHI 8'h1C
`define DMAE_A_STORE  8'h20
`define DMAE_A_PROD   8'h24

// core_config_reg fields
`define DMAE_CFG_FRAC  0
`define DMAE_CFG_USGN  1
`define DMAE_CFG_RND   2
`define DMAE_CFG_W32   4
`define DMAE_CFG_STC   5
`define DMAE_CFG_CLB   6
`define DMAE_CFG_CLA   7
`define DMAE_CFG_RST   8'h01

// command fields
`define DMAE_CMD_OP    3:0
`define DMAE_CMD_ACC   4
`define DMAE_CMD_SH    10:5
`define DMAE_CMD_XU    11
`define DMAE_CMD_YU    12
`define DMAE_CMD_BYTE  13

// status fields
`define DMAE_ST_GA     0
`define DMAE_ST_GB     1
`define DMAE_ST_SA     2
`define DMAE_ST_SB     3
`define DMAE_ST_OAB    4
`define DMAE_ST_SAB    5

// operation codes
`define DMAE_OP_CLR    4'h0
`define DMAE_OP_ED     4'h1
`define DMAE_OP_ACCUM_SQUARE_DIFF   4'h2
`define DMAE_OP_MACC   4'h3
`define DMAE_OP_PREF   4'h4
`define DMAE_OP_MLD    4'h5
`define DMAE_OP_MNLD   4'h6
`define DMAE_OP_MSUB   4'h7
`define DMAE_OP_ADDA   4'h8
`define DMAE_OP_SUBA   4'h9
`define DMAE_OP_NEGA   4'hA
`define DMAE_OP_LOAD   4'hB
`define DMAE_OP_ADDD   4'hC
`define DMAE_OP_MCU    4'hD

// clamp values and rounding half constant
`define DMAE_SAT40P    40'h7FFFFFFFFF
`define DMAE_SAT40N    40'h8000000000
`define DMAE_SAT32P    40'h007FFFFFFF
`define DMAE_SAT32N    40'h0080000000
`define DMAE_Q15P      16'h7FFF
`define DMAE_Q15N      16'h8000
`define DMAE_HALF      16'h8000

`endif

//--- testbench/dmae_host.sv
`timescale 1ns/100ps
module dmae_host
(
	input  wire        pclk,    // clock
	output reg         psel,    // select
	output reg         penable, // access phase
	output reg         pwrite,  // direction
	output reg  [7:0]  paddr,   // address
	output reg  [31:0] pwdata,  // write data
	input  wire        pready,  // answer
	input  wire [31:0] prdata   // read data
);
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// one transfer, held until pready is sampled high or 50 more cycles pass
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic ok);
		integer n;
		begin
			@(posedge pclk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			n = 0;
			@(posedge pclk);
			while (pready !== 1'b1 && n < 50)
			begin
				@(posedge pclk);
				n = n + 1;
			end
			q = prdata;
			ok = pready;
			psel <= 1'b0;
			penable <= 1'b0;
			pwdata <= ~d;
		end
	endtask
endmodule // dmae_host

//--- testbench/dmae_engine_properties.sv
`timescale 1ns/100ps
`include "dmae_defs.vh"
module dmae_checker
(
	input wire        pclk,    // clock
	input wire        presetn, // reset, low
	input wire        psel,    // select
	input wire        penable, // access
	input wire        pwrite,  // direction
	input wire [7:0]  paddr,   // address
	input wire [31:0] pwdata,  // write data
	input wire        pready,  // answer
	input wire [31:0] prdata,  // read data
	input wire        pslverr  // error
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire rd = pready && !pwrite;
	wire bad = paddr > `DMAE_A_PROD || paddr[1:0] != 2'b00;
	rdy_after_setup_a: assert property (psel && !penable |=> pready)
		else $error("no pready after setup");
	rdy_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	rdy_in_access_a: assert property (pready |-> psel && penable)
		else $error("pready outside access");
	err_unmapped_a: assert property (pready && bad |-> pslverr)
		else $error("unmapped without error");
	err_mapped_a: assert property (pready && !bad |-> !pslverr)
		else $error("error on mapped address");
	err_data_a: assert property (rd && pslverr |-> prdata == 32'h0)
		else $error("error read not zero");
	rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
		else $error("read data moved");
	cmd_reads_zero_a: assert property (
		rd && paddr == `DMAE_A_CMD |-> prdata == 32'h0)
		else $error("command reads nonzero");
	stat_or_bits_a: assert property (rd && paddr == `DMAE_A_STAT |->
		prdata[4] == (prdata[0] | prdata[1])
		&& prdata[5] == (prdata[2] | prdata[3]))
		else $error("summary flags wrong");
	acc_hi_width_a: assert property (rd && (paddr == `DMAE_A_ACCAHI ||
		paddr == `DMAE_A_ACCBHI) |-> prdata[31:8] == 24'h0)
		else $error("accumulator wider than 40");
endmodule // dmae_checker

bind dmae_engine dmae_checker chk_u
(
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.prdata(prdata), .pslverr(pslverr)
);

//--- testbench/dmae_engine_test.sv
`timescale 1ns/100ps
`include "dmae_defs.vh"
module dmae_engine_test;
	logic        pclk;
	logic        presetn;
	wire         psel;
	wire         penable;
	wire         pwrite;
	wire  [7:0]  paddr;
	wire  [31:0] pwdata;
	wire         pready;
	wire  [31:0] prdata;
	wire         pslverr;
	logic [31:0] q;
	logic        ok;
	integer      num_errors;
	integer      n_tests;
	dmae_engine dut
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr)
	);
	dmae_host host
	(
		.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata)
	);
	always #20 pclk = ~pclk;
	task conclude;
		begin
			$display("errors %0d checks %0d", num_errors, n_tests);
			if (num_errors == 0 && n_tests > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	task go(input logic w, input logic [7:0] a, input logic [31:0] d);
		begin
			host.xfer(w, a, d, q, ok);
			if (ok !== 1'b1)
			begin
				num_errors = num_errors + 1;
				$display("BAD %0t no answer", $time);
				conclude;
			end
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		go(1'b1, a, d);
	endtask
	task chk(input logic [7:0] a, input logic [31:0] e);
		begin
			go(1'b0, a, 32'h0);
			n_tests = n_tests + 1;
			if (q !== e)
			begin
				num_errors = num_errors + 1;
				$display("BAD %0t at %h got %h want %h", $time, a, q, e);
			end
		end
	endtask
	task ck40(input logic [7:0] a, input logic [39:0] e);
		begin
			chk(a, e[31:0]);
			chk(a + 8'h04, {24'h0, e[39:32]});
		end
	endtask
	task sa(input logic [7:0] a, input logic [39:0] v);
		begin
			wr(a, v[31:0]);
			wr(a + 8'h04, {24'h0, v[39:32]});
		end
	endtask
	task op(input logic [13:0] f, input logic [3:0] o,
		input logic [15:0] x, input logic [15:0] y);
		begin
			wr(`DMAE_A_OPND, {y, x});
			wr(`DMAE_A_CMD, {18'h0, f[13:4], o});
		end
	endtask
	localparam logic [7:0] A = `DMAE_A_ACCALO;
	localparam logic [13:0] N = 14'h0;
	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		num_errors = 0;
		n_tests = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		chk(`DMAE_A_CFG, 32'h01);
		chk(`DMAE_A_STAT, 32'h0);
		op(N, `DMAE_OP_MLD, `DMAE_Q15N, `DMAE_Q15N);
		ck40(A, 40'h0080000000);
		op(N, `DMAE_OP_MLD, 16'h4000, 16'hC000);
		ck40(A, 40'hFFE0000000);
		wr(`DMAE_A_CFG, 32'h0);
		op(N, `DMAE_OP_MLD, `DMAE_Q15P, `DMAE_Q15P);
		ck40(A, 40'h003FFF0001);
		op(N, `DMAE_OP_MACC, `DMAE_Q15P, `DMAE_Q15P);
		ck40(A, 40'h007FFE0002);
		op(N, `DMAE_OP_MSUB, 16'h2, 16'h3);
		ck40(A, 40'h007FFDFFFC);
		op(N, `DMAE_OP_MLD, 16'hFFFF, 16'hFFFF);
		ck40(A, 40'h1);
		wr(`DMAE_A_CFG, 32'h02);
		op(N, `DMAE_OP_MLD, 16'hFFFF, 16'hFFFF);
		ck40(A, 40'h00FFFE0001);
		wr(`DMAE_A_CFG, 32'h0);
		op(N, `DMAE_OP_MNLD, 16'h2, 16'h3);
		ck40(A, 40'hFFFFFFFFFA);
		op(N, `DMAE_OP_ED, 16'h5, 16'h2);
		ck40(A, 40'h9);
		op(N, `DMAE_OP_ACCUM_SQUARE_DIFF, 16'h5, 16'h2);
		op(N, `DMAE_OP_PREF, 16'h7, 16'h7);
		ck40(A, 40'h12);
		op(14'h010, `DMAE_OP_MLD, 16'h3, 16'h1);
		op(N, `DMAE_OP_ADDA, 16'h0, 16'h0);
		ck40(A, 40'h15);
		op(N, `DMAE_OP_SUBA, 16'h0, 16'h0);
		op(N, `DMAE_OP_NEGA, 16'h0, 16'h0);
		ck40(A, 40'hFFFFFFFFEE);
		op(N, `DMAE_OP_CLR, 16'h0, 16'h0);
		ck40(A, 40'h0);
		op(N, `DMAE_OP_LOAD, 16'h1234, 16'h0);
		ck40(A, 40'h0012340000);
		op(14'h080, `DMAE_OP_LOAD, 16'h1234, 16'h0);
		op(N, `DMAE_OP_ADDD, 16'h0001, 16'h0);
		ck40(A, 40'h0001244000);
		op(14'h7C0, `DMAE_OP_LOAD, 16'h1234, 16'h0);
		ck40(A, 40'h0048D00000);
		op(N, `DMAE_OP_MCU, 16'hFFFF, 16'h2);
		chk(`DMAE_A_PROD, 32'hFFFFFFFE);
		op(14'h800, `DMAE_OP_MCU, 16'hFFFF, 16'h2);
		chk(`DMAE_A_PROD, 32'h0001FFFE);
		op(14'h2000, `DMAE_OP_MCU, 16'h10, 16'h10);
		chk(`DMAE_A_PROD, 32'h00000100);
		op(14'h1000, `DMAE_OP_MCU, 16'h2, 16'hFFFF);
		chk(`DMAE_A_PROD, 32'h0001FFFE);
		op(14'h2000, `DMAE_OP_MCU, 16'h00FF, 16'h0002);
		chk(`DMAE_A_PROD, 32'h0000FFFE);
		wr(`DMAE_A_CFG, 32'h80);
		sa(A, `DMAE_SAT40P);
		sa(`DMAE_A_ACCBLO, 40'h1);
		op(N, `DMAE_OP_ADDA, 16'h0, 16'h0);
		ck40(A, `DMAE_SAT40P);
		chk(`DMAE_A_STAT, 32'h35);
		wr(`DMAE_A_STAT, 32'h04);
		chk(`DMAE_A_STAT, 32'h11);
		wr(`DMAE_A_CFG, 32'h90);
		sa(A, `DMAE_SAT32P);
		op(N, `DMAE_OP_ADDA, 16'h0, 16'h0);
		ck40(A, `DMAE_SAT32P);
		chk(`DMAE_A_STAT, 32'h24);
		wr(`DMAE_A_CFG, 32'h0);
		sa(A, 40'h0000028000);
		chk(`DMAE_A_STORE, 32'h3);
		wr(`DMAE_A_CFG, 32'h04);
		chk(`DMAE_A_STORE, 32'h2);
		wr(`DMAE_A_CFG, 32'h20);
		sa(A, 40'h007FFF8000);
		chk(`DMAE_A_STORE, {16'h0, `DMAE_Q15P});
		wr(`DMAE_A_CFG, 32'h50);
		sa(`DMAE_A_ACCBLO, 40'hFF80000000);
		sa(A, 40'h1);
		op(14'h010, `DMAE_OP_SUBA, 16'h0, 16'h0);
		ck40(`DMAE_A_ACCBLO, `DMAE_SAT32N);
		chk(`DMAE_A_STAT, 32'h2C);
		wr(`DMAE_A_STAT, 32'h0C);
		chk(`DMAE_A_STAT, 32'h0);
		chk(`DMAE_A_CMD, 32'h0);
		chk(8'h40, 32'h0);
		conclude;
	end
endmodule // dmae_engine_test
